/* File: buck_mode_consts.vh */
// How it works
// - Hysteretic pulse starts at lower output limit, ends at upper limit.
// - Between hysteretic pulses both gate drives stay off.
// - Forced fixed-frequency input high keeps PWM mode, never hysteretic.
// - Phase polarity sampled once per cycle, just before high side on.
// - Low phase comparator means negative phase, high means positive.
// - Continuous current with negative samples keeps PWM mode.
// - Eight consecutive positive samples in PWM enter hysteretic mode.
// - Entering hysteretic mode turns both gate drives off at once.
// - Eight consecutive negative samples in hysteretic return to PWM.
// - Output below hysteretic level changes to PWM on the third clock.
// - Low side drive waits until high side gate below one volt.
// - High side drive waits until low side gate below one volt.
// - Linear regulator has its own enable, power good, soft start.
// - Linear regulator shuts down while sense voltage exceeds 100 mV.
// - Linear regulator restarts once sense voltage drops below 100 mV.
// - Undervoltage flagged when linear output 26 percent below nominal.
// - Converter power good low while output outside regulation window.
`ifndef BUCK_MODE_CONSTS_VH
`define BUCK_MODE_CONSTS_VH
`define MODE_PWM 1'b0
`define MODE_HYST 1'b1
`define SAMPLE_RUN 4'h8
`define CNT_W 4
`endif

/* File: buck_mode_control.v */
`timescale 1ns/10ps
`include "buck_mode_consts.vh"
module buck_mode_control #(
    parameter RUN_LEN = `SAMPLE_RUN
) (
    // Clock and reset.
    input wire clock,
    input wire nrst,
    // Converter control.
    input wire converter_enable,
    input wire force_fixed_freq,
    input wire pwm_request,
    input wire phase_comp,
    input wire out_below_lower,
    input wire out_above_upper,
    input wire out_below_hyst_level,
    input wire out_in_window,
    input wire converter_soft_start_done,
    // Adaptive dead time sense.
    input wire high_gate_low,
    input wire low_gate_low,
    // Gate drives and converter status.
    output reg high_side_drive,
    output reg low_side_drive,
    output reg hyst_mode,
    output reg converter_power_good,
    // Linear regulator.
    input wire linear_regulator_enable,
    input wire linear_regulator_soft_start_done,
    input wire linear_regulator_over_current,
    input wire linear_regulator_under_26pct,
    output reg linear_regulator_on,
    output reg linear_regulator_power_good,
    output reg linear_regulator_undervoltage
);

// ****************************************
// Helper functions
// ****************************************
// The polarity that a run must have to change the mode: positive
// samples lead out of PWM, negative samples out of hysteretic mode.
function wanted_pol;
    input mode;
    begin
        wanted_pol = ~mode;
    end
endfunction

// A sample extends the run only if it has the wanted polarity and
// matches the polarity of the run being counted.
function extends_run;
    input pol;
    input run_pol;
    input mode;
    begin
        extends_run = (pol == wanted_pol(mode)) && (pol == run_pol);
    end
endfunction

// A broken run restarts at one if the breaking sample has the wanted
// polarity, and at zero otherwise.
function [`CNT_W-1:0] restart_count;
    input pol;
    input mode;
    begin
        restart_count = {`CNT_W{1'b0}};
        if (pol == wanted_pol(mode))
            restart_count = {{(`CNT_W-1){1'b0}}, 1'b1};
    end
endfunction

// ****************************************
// Input synchronisers
// ****************************************
// Every comparator result and control pin is asynchronous to the
// clock, so each passes two flip-flops at a cost of two cycles.
localparam NS = 15;
wire [NS-1:0] raw_in;
assign raw_in[14] = converter_enable;
assign raw_in[13] = force_fixed_freq;
assign raw_in[12] = pwm_request;
assign raw_in[11] = phase_comp;
assign raw_in[10] = out_below_lower;
assign raw_in[9] = out_above_upper;
assign raw_in[8] = out_below_hyst_level;
assign raw_in[7] = out_in_window;
assign raw_in[6] = converter_soft_start_done;
assign raw_in[5] = high_gate_low;
assign raw_in[4] = low_gate_low;
assign raw_in[3] = linear_regulator_enable;
assign raw_in[2] = linear_regulator_over_current;
assign raw_in[1] = linear_regulator_under_26pct;
assign raw_in[0] = linear_regulator_soft_start_done;
wire [NS-1:0] synced;
genvar gi;
generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
        reg first;
        reg second;
        always @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                first <= 1'b0;
                second <= 1'b0;
            end else begin
                first <= raw_in[gi];
                second <= first;
            end
        end
        assign synced[gi] = second;
    end
endgenerate

// Converter side.
wire en_s = synced[14];
wire force_s = synced[13];
wire req_s = synced[12];
wire phase_pos = synced[11];
wire below_low_s = synced[10];
wire above_up_s = synced[9];
wire below_hyst_s = synced[8];
wire in_win_s = synced[7];
wire ss_done_s = synced[6];
wire hg_low_s = synced[5];
wire lg_low_s = synced[4];
// Linear regulator side.
wire lin_en_s = synced[3];
wire lin_oc_s = synced[2];
wire lin_uv_s = synced[1];
wire lss_s = synced[0];

// ****************************************
// Phase sampling
// ****************************************
// In PWM mode the phase is sampled as the synchronised request rises:
// the low side has been conducting and the high side is about to turn
// on. In hysteretic mode each pulse start is a sample.
reg req_d;
reg pulse_on;
wire req_rise = req_s & ~req_d;
wire sample = req_rise & ~hyst_mode;
wire hyst_sample = hyst_mode & below_low_s & ~pulse_on;
wire take = sample | hyst_sample;

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        req_d <= 1'b0;
    end else begin
        req_d <= req_s;
    end
end

// ****************************************
// Mode control
// ****************************************
// The run length is cut to the counter width on purpose, so RUN_LEN
// must not exceed the counter's range.
wire [31:0] run_end = RUN_LEN - 1;
wire [`CNT_W-1:0] last = run_end[`CNT_W-1:0];
wire [`CNT_W-1:0] zero = {`CNT_W{1'b0}};
wire [`CNT_W-1:0] one = {{(`CNT_W-1){1'b0}}, 1'b1};
reg [`CNT_W-1:0] count;
reg count_pol;
reg [`CNT_W-1:0] next_count;
reg next_mode;
reg next_count_pol;
wire extend = extends_run(phase_pos, count_pol, hyst_mode);
wire [`CNT_W-1:0] restart = restart_count(phase_pos, hyst_mode);

always @* begin
    next_count = count;
    next_mode = hyst_mode;
    next_count_pol = count_pol;
    if (take)
        next_count_pol = phase_pos;
    case (hyst_mode)
        `MODE_PWM: begin
            if (!en_s || force_s) begin
                next_count = zero;
            end else if (sample) begin
                if (!extend) begin
                    next_count = restart;
                end else if (count == last) begin
                    next_mode = `MODE_HYST;
                    next_count = zero;
                end else begin
                    next_count = count + one;
                end
            end
        end
        `MODE_HYST: begin
            if (!en_s || force_s) begin
                next_mode = `MODE_PWM;
                next_count = zero;
            end else if (below_hyst_s) begin
                next_mode = `MODE_PWM;
                next_count = zero;
            end else if (hyst_sample) begin
                if (!extend) begin
                    next_count = restart;
                end else if (count == last) begin
                    next_mode = `MODE_PWM;
                    next_count = zero;
                end else begin
                    next_count = count + one;
                end
            end
        end
        default: begin
            next_mode = `MODE_PWM;
            next_count = zero;
        end
    endcase
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        hyst_mode <= `MODE_PWM;
        count <= {`CNT_W{1'b0}};
    end else begin
        hyst_mode <= next_mode;
        count <= next_count;
    end
end

// The polarity of the run in progress is kept apart from the mode, so
// that a sample of either kind updates it, even while PWM is forced.
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        count_pol <= 1'b0;
    end else begin
        count_pol <= next_count_pol;
    end
end

wire mode_change = next_mode != hyst_mode;

// ****************************************
// Hysteretic pulse
// ****************************************
// A pulse runs from the lower limit to the upper limit of the output.
// It is dropped on any mode change, so none survives into PWM mode.
reg next_pulse;

always @* begin
    next_pulse = pulse_on;
    if (!hyst_mode || mode_change)
        next_pulse = 1'b0;
    else if (pulse_on && above_up_s)
        next_pulse = 1'b0;
    else if (below_low_s)
        next_pulse = 1'b1;
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        pulse_on <= 1'b0;
    end else begin
        pulse_on <= next_pulse;
    end
end

// ****************************************
// Gate interlock
// ****************************************
// The low side only conducts in PWM mode, so in hysteretic mode both
// drives are off between pulses and the low switch acts as a diode.
wire want_high = hyst_mode ? pulse_on : req_s;
wire want_low = hyst_mode ? 1'b0 : ~req_s;
reg next_high;
reg next_low;

// Each drive waits for the other gate to be sensed low. That sense is
// two cycles old, so the other drive's own last state is checked too;
// every edge thus gets at least one cycle of dead time.
always @* begin
    next_high = 1'b0;
    next_low = 1'b0;
    if (en_s && !mode_change) begin
        next_high = want_high & ~low_side_drive & lg_low_s;
        next_low = want_low & ~high_side_drive & hg_low_s;
    end
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        high_side_drive <= 1'b0;
        low_side_drive <= 1'b0;
    end else begin
        high_side_drive <= next_high;
        low_side_drive <= next_low;
    end
end

// ****************************************
// Converter power good
// ****************************************
// Power good stays low until soft start is done and the output is
// inside its regulation window.
wire next_power_good = en_s & ss_done_s & in_win_s;

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        converter_power_good <= 1'b0;
    end else begin
        converter_power_good <= next_power_good;
    end
end

// ****************************************
// Linear regulator protection
// ****************************************
// The linear regulator has its own enable and soft start. It restarts
// by itself once the overcurrent has gone; there is no latch, so a hard
// short makes it cycle at the pace of the current comparator.
wire next_lin_on = lin_en_s & ~lin_oc_s;
wire next_lin_uv = lin_en_s & lin_uv_s;
wire next_lin_pg = lin_en_s & lss_s & ~lin_oc_s & ~lin_uv_s;

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        linear_regulator_on <= 1'b0;
    end else begin
        linear_regulator_on <= next_lin_on;
    end
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        linear_regulator_undervoltage <= 1'b0;
    end else begin
        linear_regulator_undervoltage <= next_lin_uv;
    end
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        linear_regulator_power_good <= 1'b0;
    end else begin
        linear_regulator_power_good <= next_lin_pg;
    end
end

endmodule // buck_mode_control

/* File: buck_gate_model.sv */
`timescale 1ns/10ps
// ****
// Gate discharge model.
// ****
module buck_gate_model (
    // Clock.
    input wire clock,
    // Gate drives.
    input wire high_side_drive,
    input wire low_side_drive,
    // Gate sense.
    output reg high_gate_low = 1'b1,
    output reg low_gate_low = 1'b1
);
    // A gate takes one edge to discharge below its threshold.
    always @(posedge clock) begin
        high_gate_low <= !high_side_drive;
        low_gate_low <= !low_side_drive;
    end
endmodule // buck_gate_model

/* File: buck_mode_control_properties.sv */
`timescale 1ns/10ps
// ****
// Mode, gate, linear regulator and power good checks.
// ****
module buck_mode_checker (
    // Clock and reset.
    input wire clock,
    input wire nrst,
    // Watched ports.
    input wire converter_enable,
    input wire force_fixed_freq,
    input wire out_below_hyst_level,
    input wire out_in_window,
    input wire linear_regulator_over_current,
    input wire high_side_drive,
    input wire low_side_drive,
    input wire hyst_mode,
    input wire converter_power_good,
    input wire linear_regulator_on
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_no_shoot: assert property (!(high_side_drive && low_side_drive))
        else $error("both gate drives on");
    a_low_waits: assert property ($rose(low_side_drive) |-> !$past(high_side_drive))
        else $error("low drive without dead time");
    a_high_waits: assert property ($rose(high_side_drive) |-> !$past(low_side_drive))
        else $error("high drive without dead time");
    a_force_pwm: assert property (force_fixed_freq [*3] |=> !hyst_mode)
        else $error("hysteretic under forced pwm");
    a_enter_off: assert property ($rose(hyst_mode) |-> !high_side_drive && !low_side_drive)
        else $error("drive on at mode entry");
    a_hyst_no_low: assert property (hyst_mode |-> !low_side_drive)
        else $error("low drive in hysteretic mode");
    a_disable_pwm: assert property (!converter_enable [*3] |=> !hyst_mode)
        else $error("hysteretic while disabled");
    a_load_step: assert property (hyst_mode && $rose(out_below_hyst_level) |-> ##[1:3] !hyst_mode)
        else $error("load step kept hysteretic");
    a_ldo_trip: assert property (linear_regulator_over_current [*3] |=> !linear_regulator_on)
        else $error("linear regulator on in overcurrent");
    a_pg_window: assert property (!out_in_window [*3] |=> !converter_power_good)
        else $error("power good outside window");
endmodule // buck_mode_checker
bind buck_mode_control buck_mode_checker chk (.*);

/* File: test_buck_mode_control.sv */
`timescale 1ns/10ps
module test_buck_mode_control;
    reg clock = 1'b0, nrst = 1'b0, converter_enable = 1'b0;
    reg force_fixed_freq = 1'b0, pwm_request = 1'b0, phase_comp = 1'b0;
    reg out_below_lower = 1'b0, out_above_upper = 1'b0;
    reg out_below_hyst_level = 1'b0, out_in_window = 1'b0;
    reg converter_soft_start_done = 1'b0, linear_regulator_enable = 1'b0;
    reg linear_regulator_soft_start_done = 1'b0;
    reg linear_regulator_over_current = 1'b0;
    reg linear_regulator_under_26pct = 1'b0;
    wire high_gate_low, low_gate_low, high_side_drive, low_side_drive;
    wire hyst_mode, converter_power_good, linear_regulator_on;
    wire linear_regulator_power_good, linear_regulator_undervoltage;
    integer miscompares = 0, tests_run = 0, test_no = 0;
    integer run = 0, i = 0;
    reg exp_mode = 1'b0, v = 1'b0;
    buck_mode_control dut (.*);
    buck_gate_model far_side (.*);
    always #5 clock = !clock;
    function logic run_done(input integer n);
        return n >= 8;
    endfunction
    function integer next_run(input integer r, input logic agree);
        return agree ? r + 1 : 0;
    endfunction
    task chk(input logic seen, input logic want, input string what);
        tests_run = tests_run + 1;
        if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %b seen %b", what, want, seen);
        end
    endtask
    task settle;
        repeat (4) @(posedge clock);
        #1;
    endtask
    task done;
        test_no = test_no + 1;
        $display("test %0d finished", test_no);
    endtask
    // Phase samples with random idle gaps; m selects hysteretic pulses.
    task pulses(input logic m, input integer n, input logic v);
        repeat (n) begin
            @(posedge clock);
            phase_comp <= v;
            if (m) out_below_lower <= 1'b1;
            else pwm_request <= 1'b1;
            repeat (3) @(posedge clock);
            out_below_lower <= 1'b0;
            pwm_request <= 1'b0;
            out_above_upper <= m;
            repeat (2 + $urandom % 3) @(posedge clock);
            out_above_upper <= 1'b0;
        end
        settle;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1031));
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
        chk(hyst_mode, 1'b0, "reset mode");
        chk(linear_regulator_on, 1'b0, "reset ldo");
        @(posedge clock);
        converter_enable <= 1'b1;
        pulses(1'b0, 7, 1'b1);
        pulses(1'b0, 1, 1'b0);
        pulses(1'b0, 7, 1'b1);
        chk(hyst_mode, run_done(7), "broken run");
        pulses(1'b0, 1, 1'b1);
        chk(hyst_mode, run_done(8), "enter hyst");
        chk(high_side_drive, 1'b0, "hyst idle high");
        chk(low_side_drive, 1'b0, "hyst idle low");
        done;
        pulses(1'b1, 7, 1'b0);
        chk(hyst_mode, !run_done(7), "short neg run");
        pulses(1'b1, 1, 1'b0);
        chk(hyst_mode, !run_done(8), "leave hyst");
        chk(low_side_drive, 1'b1, "pwm low side");
        chk(high_side_drive, 1'b0, "pwm high side");
        done;
        pulses(1'b0, 8, 1'b1);
        @(posedge clock);
        out_below_hyst_level <= 1'b1;
        settle;
        chk(hyst_mode, 1'b0, "load step");
        out_below_hyst_level <= 1'b0;
        force_fixed_freq <= 1'b1;
        pulses(1'b0, 8, 1'b1);
        chk(hyst_mode, 1'b0, "forced pwm");
        done;
        @(posedge clock);
        {linear_regulator_enable, linear_regulator_soft_start_done} <= 2'h3;
        {converter_soft_start_done, out_in_window} <= 2'h3;
        settle;
        chk(linear_regulator_on, 1'b1, "ldo on");
        chk(linear_regulator_power_good, 1'b1, "ldo pg");
        chk(converter_power_good, 1'b1, "pg in window");
        linear_regulator_over_current <= 1'b1;
        out_in_window <= 1'b0;
        settle;
        chk(linear_regulator_on, 1'b0, "ldo trip");
        chk(converter_power_good, 1'b0, "pg out of window");
        linear_regulator_over_current <= 1'b0;
        linear_regulator_under_26pct <= 1'b1;
        settle;
        chk(linear_regulator_on, 1'b1, "ldo restart");
        chk(linear_regulator_undervoltage, 1'b1, "ldo low");
        chk(linear_regulator_power_good, 1'b0, "ldo pg low");
        done;
        @(posedge clock);
        force_fixed_freq <= 1'b0;
        settle;
        for (i = 0; i < 40; i = i + 1) begin
            v = exp_mode ? ($urandom % 4 == 0) : ($urandom % 4 != 0);
            pulses(exp_mode, 1, v);
            run = next_run(run, v != exp_mode);
            if (run_done(run)) begin
                exp_mode = !exp_mode;
                run = 0;
            end
            chk(hyst_mode, exp_mode, "random mode");
        end
        done;
        if (!exp_mode) pulses(1'b0, 8, 1'b1);
        chk(hyst_mode, 1'b1, "before reset");
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
        chk(hyst_mode, 1'b0, "mid reset mode");
        chk(high_side_drive, 1'b0, "mid reset drive");
        done;
        finish_test;
    end
endmodule // test_buck_mode_control
